/* rtl/sbgt_timer.sv */
/*
 * Gated 16-bit timer with period match, gate accumulation, idle/sleep
 * control and a sticky, maskable interrupt. Registers on Avalon-MM.
 * Assumes gate_clock_pin, cpu_idle and cpu_sleep are synchronous to clk_sys
 * except that gate mode and the synchronous external mode still resynchronise the pin.
 */
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sbgt_timer (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic [sbgt_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [sbgt_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [sbgt_pkg::DATA_W-1:0] avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        gate_clock_pin,
    input  wire logic                        cpu_idle,
    input  wire logic                        cpu_sleep,
    output logic                             irq
);

    localparam int RW = sbgt_pkg::REG_W;
    localparam logic [sbgt_pkg::INSTR_CNT_W-1:0] INSTR_LAST =
        sbgt_pkg::INSTR_CNT_W'(sbgt_pkg::INSTR_DIV - 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [sbgt_pkg::ADDR_W-1:0] addr,
                                 input logic [sbgt_pkg::ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic [RW-1:0] merge16(input logic [RW-1:0] old,
                                              input logic [RW-1:0] wdata,
                                              input logic [1:0]    be);
        merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    endfunction : merge16

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [RW-1:0] timer_control_register;
    logic [RW-1:0] count_register;
    logic [RW-1:0] period;
    logic [RW-1:0] irq_enable_reg_0;
    logic          period_match_flag;
    logic          flag_snap;
    logic          ack;
    logic [sbgt_pkg::INSTR_CNT_W-1:0] instr_div;
    logic          gate_meta;
    logic          gate_sync;
    logic          gate_sync_d;
    logic          gate_raw_d;

    logic          timer_on;
    logic          stop_in_idle;
    logic          gate_accumulate_enable;
    logic [1:0]    prescale_select;
    logic          external_sync_select;
    logic          clock_source_select;

    logic          req;
    logic          wr_ok;
    logic          rd_ok;
    logic          ctrl_wr;
    logic          count_wr;
    logic          period_wr;
    logic          mask_wr;
    logic          status_rd;
    logic          presc_clear;
    logic          instruction_cycle_clock;
    logic          idle_halt;
    logic          gate_mode;
    logic          gate_fall;
    logic          ext_async_edge;
    logic          ext_sync_edge;
    logic          tick_in;
    logic          ps_tick;
    logic          match_evt;
    logic          gate_end_evt;
    logic          flag_set;
    logic [RW-1:0] next_count;

    assign timer_on               = timer_control_register[sbgt_pkg::BIT_ON];
    assign stop_in_idle           = timer_control_register[sbgt_pkg::BIT_SIDL];
    assign gate_accumulate_enable = timer_control_register[sbgt_pkg::BIT_GATE];
    assign prescale_select        =
        timer_control_register[sbgt_pkg::BIT_PS_HI:sbgt_pkg::BIT_PS_LO];
    assign external_sync_select   = timer_control_register[sbgt_pkg::BIT_SYNC];
    assign clock_source_select    = timer_control_register[sbgt_pkg::BIT_SRC];

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle, writes land at the ack edge
    // ------------------------------------------------------------
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack;
    assign wr_ok           = avs_write && ack;
    assign rd_ok           = avs_read && ack;
    assign ctrl_wr   = wr_ok && hit(avs_address, sbgt_pkg::OFF_CTRL)   && |avs_byteenable[1:0];
    assign count_wr  = wr_ok && hit(avs_address, sbgt_pkg::OFF_COUNT)  && |avs_byteenable[1:0];
    assign period_wr = wr_ok && hit(avs_address, sbgt_pkg::OFF_PERIOD) && |avs_byteenable[1:0];
    assign mask_wr   = wr_ok && hit(avs_address, sbgt_pkg::OFF_MASK)   && |avs_byteenable[1:0];
    assign status_rd = rd_ok && hit(avs_address, sbgt_pkg::OFF_STATUS);

    // Ack rises once per request, so back-to-back requests each wait once
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    // Read data is caught one edge early so it stands at the ack edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= '0;
            flag_snap    <= 1'b0;
        end else if (avs_read && !ack) begin
            flag_snap <= hit(avs_address, sbgt_pkg::OFF_STATUS) && period_match_flag;
            if (hit(avs_address, sbgt_pkg::OFF_CTRL)) begin
                avs_readdata <= {{(sbgt_pkg::DATA_W-RW){1'b0}}, timer_control_register};
            end else if (hit(avs_address, sbgt_pkg::OFF_COUNT)) begin
                avs_readdata <= {{(sbgt_pkg::DATA_W-RW){1'b0}}, count_register};
            end else if (hit(avs_address, sbgt_pkg::OFF_PERIOD)) begin
                avs_readdata <= {{(sbgt_pkg::DATA_W-RW){1'b0}}, period};
            end else if (hit(avs_address, sbgt_pkg::OFF_STATUS)) begin
                avs_readdata <= {{(sbgt_pkg::DATA_W-1){1'b0}}, period_match_flag};
            end else if (hit(avs_address, sbgt_pkg::OFF_MASK)) begin
                avs_readdata <= {{(sbgt_pkg::DATA_W-RW){1'b0}}, irq_enable_reg_0};
            end else begin
                avs_readdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timer_control_register <= sbgt_pkg::RST_CTRL;
        end else if (ctrl_wr) begin
            timer_control_register <= merge16(timer_control_register,
                avs_writedata[RW-1:0], avs_byteenable[1:0]) & sbgt_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            period <= sbgt_pkg::RST_PERIOD;
        end else if (period_wr) begin
            period <= merge16(period, avs_writedata[RW-1:0], avs_byteenable[1:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_enable_reg_0 <= sbgt_pkg::RST_MASK;
        end else if (mask_wr) begin
            irq_enable_reg_0 <= merge16(irq_enable_reg_0, avs_writedata[RW-1:0],
                avs_byteenable[1:0]) & sbgt_pkg::STAT_MASK;
        end
    end

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    // Free-running: the first internal tick after turn-on lands anywhere in four cycles
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            instr_div <= '0;
        end else begin
            instr_div <= instr_div + 1'b1;
        end
    end
    assign instruction_cycle_clock = (instr_div == INSTR_LAST);       // RULE_05

    // gate_meta feeds gate_sync only; edges are taken after the second stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gate_meta   <= 1'b0;
            gate_sync   <= 1'b0;
            gate_sync_d <= 1'b0;
            gate_raw_d  <= 1'b0;
        end else begin
            gate_meta   <= gate_clock_pin;                              // RULE_16
            gate_sync   <= gate_meta;
            gate_sync_d <= gate_sync;
            gate_raw_d  <= gate_clock_pin;
        end
    end
    assign ext_sync_edge  = gate_sync && !gate_sync_d;                 // RULE_16
    assign ext_async_edge = gate_clock_pin && !gate_raw_d;
    assign gate_fall      = !gate_sync && gate_sync_d;

    // An external source ignores the gate bit; gate events need the internal clock
    assign gate_mode = timer_on && !clock_source_select && gate_accumulate_enable; // RULE_02
    assign idle_halt = cpu_idle && stop_in_idle;                       // RULE_03

    // Sleep stops the core clock, so only the unsynchronised pin path survives it
    always_comb begin
        tick_in = 1'b0;
        if (timer_on && !idle_halt) begin
            if (!clock_source_select) begin
                tick_in = instruction_cycle_clock && !cpu_sleep
                       && (!gate_accumulate_enable || gate_sync);      // RULE_01
            end else if (external_sync_select) begin
                tick_in = ext_sync_edge && !cpu_sleep;                 // RULE_16
            end else begin
                tick_in = ext_async_edge;                              // RULE_09
            end
        end
    end

    // A halted prescaler has no clock, so the write that turns the timer on cannot clear it
    assign presc_clear = (count_wr || ctrl_wr) && timer_on;            // RULE_06 RULE_07

    sbgt_prescaler #(
        .PS_W      (sbgt_pkg::PS_W)
    ) u_prescaler (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .enable    (timer_on),
        .clear     (presc_clear),
        .ratio_sel (prescale_select),
        .tick_in   (tick_in),
        .tick_out  (ps_tick)
    );

    // ------------------------------------------------------------
    // Count and interrupt
    // ------------------------------------------------------------
    // A count write beats a tick on the same edge, and that tick is no match
    assign match_evt    = ps_tick && (count_register == period) && !count_wr; // RULE_11
    assign gate_end_evt = gate_mode && gate_fall;                      // RULE_13
    assign flag_set     = match_evt || gate_end_evt;                   // RULE_15

    always_comb begin
        next_count = count_register;
        if (count_wr) begin
            next_count = merge16(count_register, avs_writedata[RW-1:0],
                                 avs_byteenable[1:0]);                 // RULE_08
        end else if (ps_tick) begin
            next_count = (count_register == period) ?
                         sbgt_pkg::RST_COUNT : count_register + 1'b1;  // RULE_10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_register <= sbgt_pkg::RST_COUNT;
        end else begin
            count_register <= next_count;
        end
    end

    // Only a reported flag is cleared; a new event on the same edge wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            period_match_flag <= 1'b0;
        end else begin
            period_match_flag <= flag_set
                || (period_match_flag && !(status_rd && flag_snap));   // RULE_12
        end
    end

    // Level request: stays up until software reads the status register or clears the enable bit
    assign irq = period_match_flag && irq_enable_reg_0[sbgt_pkg::BIT_MATCH]; // RULE_14

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_gate_low_hold : assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
        gate_mode && !gate_sync && !count_wr |=> $stable(count_register))
        else $error("count moved with gate low");

    a_gate_needs_int : assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
        timer_on && clock_source_select && !external_sync_select && !idle_halt
        && ext_async_edge |-> tick_in && !gate_end_evt)
        else $error("gate bit held back external count");

    a_idle_stop : assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
        idle_halt && !count_wr |=> $stable(count_register))
        else $error("count moved in stopped idle");

    a_instr_div4 : assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
        instruction_cycle_clock |=> !instruction_cycle_clock [*3] ##1 instruction_cycle_clock)
        else $error("instruction tick not every four cycles");

    a_ctrl_keeps_count : assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
        ctrl_wr && !ps_tick |=> $stable(count_register))
        else $error("control write changed count");

    a_sleep_stop : assert property (@(posedge clk_sys) disable iff (reset) // RULE_09
        cpu_sleep && !(timer_on && clock_source_select && !external_sync_select)
        && !count_wr |=> $stable(count_register))
        else $error("count moved in sleep");

    a_wrap_zero : assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
        ps_tick && count_register == period && !count_wr
        |=> count_register == sbgt_pkg::RST_COUNT)
        else $error("no wrap at period");

    a_match_flag : assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
        match_evt |=> period_match_flag)
        else $error("match did not set flag");

    a_flag_sticky : assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
        period_match_flag && !status_rd |=> period_match_flag)
        else $error("flag cleared without read");

    a_gate_fall_flag : assert property (@(posedge clk_sys) disable iff (reset) // RULE_13
        gate_mode && $fell(gate_sync) |=> period_match_flag)
        else $error("gate fall did not set flag");

    a_irq_follows : assert property (@(posedge clk_sys) disable iff (reset) // RULE_14
        flag_set && irq_enable_reg_0[sbgt_pkg::BIT_MATCH] && !mask_wr |=> irq)
        else $error("enabled event gave no interrupt");

    a_flag_unmasked : assert property (@(posedge clk_sys) disable iff (reset) // RULE_15
        flag_set && !irq_enable_reg_0[sbgt_pkg::BIT_MATCH] |=> period_match_flag)
        else $error("masked event lost its flag");

    a_bus_one_wait : assert property (@(posedge clk_sys) disable iff (reset)
        req && !ack |=> !avs_waitrequest)
        else $error("bus answer late");

    // Scenarios the bench is meant to reach
    c_wrap : cover property (@(posedge clk_sys) disable iff (reset) match_evt);
    c_gate_end : cover property (@(posedge clk_sys) disable iff (reset) gate_end_evt);
    c_irq_clear : cover property (@(posedge clk_sys) disable iff (reset)
        irq ##1 status_rd ##1 !irq);
    c_async_sleep : cover property (@(posedge clk_sys) disable iff (reset)
        cpu_sleep && ps_tick);
    c_sync_tick : cover property (@(posedge clk_sys) disable iff (reset)
        external_sync_select && ps_tick);

endmodule : sbgt_timer

/* rtl/sbgt_pkg.sv */
/*
 * Constants shared by the gated 16-bit timer and its prescaler:
 * register offsets, field positions, reset values and divider figures.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
// How it works
// (RULE_01) Gate mode, control bit 6, counts instruction ticks only while gate pin high.
// (RULE_02) Gate mode works only with timer on and internal clock source selected.
// (RULE_03) Idle stops counting when stop-in-idle is 1; otherwise counting continues.
// (RULE_04) Prescale field bits 5:4 divides input by 1, 8, 64 or 256.
// (RULE_05) Input clock is oscillator divided by 4, or the external pin.
// (RULE_06) Prescaler clears on count write, control write and any reset.
// (RULE_07) With the timer off, writes do not clear the halted prescaler.
// (RULE_08) Control writes leave the count alone; only count writes change it.
// (RULE_09) Sleep counting only when on, external source, and sync bit 2 is 0.
// (RULE_10) Count runs up to the period value, then returns to zero next increment.
// (RULE_11) Count equal to period sets the timer flag; enable gates the request.
// (RULE_12) Software clears the flag; hardware never clears it on its own.
// (RULE_13) In gate mode, a falling gate edge also sets the timer flag.
// (RULE_14) The timer request is passed or blocked by the flag enable bit.
// (RULE_15) The flag sets on its condition whatever the enable bit says.
// (RULE_16) Synchronous external mode passes pin edges through a synchroniser; stops in sleep.
package sbgt_pkg;

    // ------------------------------------------------------------
    // Bus and register layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNT  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 5'h10;

    // ------------------------------------------------------------
    // Control, status and mask fields
    // ------------------------------------------------------------
    localparam int BIT_ON    = 15;
    localparam int BIT_SIDL  = 13;
    localparam int BIT_GATE  = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_SYNC  = 2;
    localparam int BIT_SRC   = 1;
    localparam int BIT_MATCH = 0;

    localparam logic [REG_W-1:0] CTRL_MASK  = 16'hA076;
    localparam logic [REG_W-1:0] STAT_MASK  = 16'h0001;
    localparam logic [REG_W-1:0] RST_CTRL   = 16'h0000;
    localparam logic [REG_W-1:0] RST_COUNT  = 16'h0000;
    localparam logic [REG_W-1:0] RST_PERIOD = 16'hFFFF;
    localparam logic [REG_W-1:0] RST_MASK   = 16'h0000;

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    localparam int INSTR_DIV   = 4;
    localparam int INSTR_CNT_W = 2;
    localparam int PS_W        = 8;

    localparam logic [1:0] PS_SEL_1   = 2'h0;
    localparam logic [1:0] PS_SEL_8   = 2'h1;
    localparam logic [1:0] PS_SEL_64  = 2'h2;
    localparam logic [1:0] PS_SEL_256 = 2'h3;

    localparam logic [PS_W-1:0] PS_LIM_1   = 8'h00;
    localparam logic [PS_W-1:0] PS_LIM_8   = 8'h07;
    localparam logic [PS_W-1:0] PS_LIM_64  = 8'h3F;
    localparam logic [PS_W-1:0] PS_LIM_256 = 8'hFF;

endpackage : sbgt_pkg

/* rtl/sbgt_prescaler.sv */
/*
 * Prescaler: passes one of every 1, 8, 64 or 256 input ticks.
 * Assumes tick_in is a one-cycle pulse in the clk_sys domain.
 */
`timescale 1ns/1ps
module sbgt_prescaler #(
    parameter int PS_W = sbgt_pkg::PS_W
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       enable,
    input  wire logic       clear,
    input  wire logic [1:0] ratio_sel,
    input  wire logic       tick_in,
    output logic            tick_out
);

    logic [PS_W-1:0] cnt;
    logic [PS_W-1:0] limit;

    function automatic logic [PS_W-1:0] ratio_limit(input logic [1:0] sel);
        unique case (sel)
            sbgt_pkg::PS_SEL_1:   ratio_limit = PS_W'(sbgt_pkg::PS_LIM_1);
            sbgt_pkg::PS_SEL_8:   ratio_limit = PS_W'(sbgt_pkg::PS_LIM_8);
            sbgt_pkg::PS_SEL_64:  ratio_limit = PS_W'(sbgt_pkg::PS_LIM_64);
            sbgt_pkg::PS_SEL_256: ratio_limit = PS_W'(sbgt_pkg::PS_LIM_256);
        endcase
    endfunction : ratio_limit

    assign limit    = ratio_limit(ratio_sel);                       // RULE_04
    assign tick_out = enable && tick_in && (cnt >= limit) && !clear;

    // A halted prescaler ignores clears; only reset reaches it then
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt <= '0;                                              // RULE_06
        end else if (enable) begin                                  // RULE_07
            if (clear) begin
                cnt <= '0;                                          // RULE_06
            end else if (tick_in) begin
                cnt <= (cnt >= limit) ? '0 : cnt + 1'b1;
            end
        end
    end

    a_ps_clear_zero : assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
        enable && clear |=> cnt == '0)
        else $error("prescaler not cleared by write");
    a_ps_halt_hold : assert property (@(posedge clk_sys) disable iff (reset) // RULE_07
        !enable |=> $stable(cnt))
        else $error("halted prescaler changed");
    a_ps_ratio_out : assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
        tick_out |-> cnt == limit)
        else $error("prescaler output off ratio");

endmodule : sbgt_prescaler

/* test/sbgt_pin_model.sv */
/* Model of the part driving the gate/clock pin: a gate level or a burst of pulses.
   Assumes it runs on the bench clock and that the pin has no pull. */
`timescale 1ns/1ps
module sbgt_pin_model (
    input  wire logic       clk_sys,
    input  wire logic       gate_high,
    input  wire logic       pulse_go,
    input  wire logic [7:0] pulse_n,
    output logic            pin,
    output logic            busy
);
    logic [7:0] left = 8'h00;
    logic [2:0] phase = 3'h0;
    // Four cycles low, then four high: slow enough for the two-flop synchroniser
    always_ff @(posedge clk_sys) begin
        if (pulse_go) begin
            left <= pulse_n;
            phase <= 3'h0;
        end else if (busy) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) begin
                left <= left - 8'h01;
            end
        end
    end
    assign busy = left != 8'h00;
    assign pin = gate_high | (busy & phase[2]);
endmodule : sbgt_pin_model

/* test/tb_sixteen_bit_gated_timer.sv */
/* Bench for the gated 16-bit timer: Avalon-MM register tasks and a pin model.
   Assumes the single 250 MHz clk_sys and the one-wait bus answer. */
`timescale 1ns/1ps
module tb_sixteen_bit_gated_timer;
    logic        clk_sys = 1'b0, reset = 1'b1, cpu_idle = 1'b0, cpu_sleep = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, gate_high = 1'b0, pulse_go = 1'b0;
    logic        avs_waitrequest, irq, pin, busy;
    logic [4:0]  avs_address = 5'h00;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [7:0]  pulse_n = 8'h00;
    logic [15:0] rd;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    int          mismatches = 0, n_tests = 0;
    int          ps_exp [4] = '{512, 64, 8, 2};
    always #2 clk_sys = ~clk_sys;
    sbgt_timer uut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gate_clock_pin(pin), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .irq(irq));
    sbgt_pin_model pm (.clk_sys(clk_sys), .gate_high(gate_high), .pulse_go(pulse_go),
        .pulse_n(pulse_n), .pin(pin), .busy(busy));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Held until waitrequest is sampled low; an idle edge follows the release
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= ~w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input string what, input logic [4:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        check(what, rd, exp);
    endtask : rc
    // Start phase of the divide-by-4 is free-running, so allow one count either way
    function automatic logic [15:0] near(input logic [15:0] v, input logic [15:0] e);
        return {15'h0000, v + 16'h0001 >= e && v <= e + 16'h0001};
    endfunction : near
    task automatic pulses(input logic [7:0] n);
        pulse_n <= n;
        pulse_go <= 1'b1;
        @(posedge clk_sys);
        pulse_go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        while (busy === 1'b1) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
    endtask : pulses
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rc("ctrl", 5'h00, sbgt_pkg::RST_CTRL);
        rc("unmapped", 5'h14, 16'h0000);
        avs_byteenable <= 4'h0;
        wr(5'h08, 16'h0000);
        avs_byteenable <= 4'hF;
        rc("period", 5'h08, sbgt_pkg::RST_PERIOD);
        wr(5'h04, 16'h1234);
        wr(5'h00, 16'h7FF9);
        rc("ctrl bits", 5'h00, 16'h7FF9 & sbgt_pkg::CTRL_MASK);
        rc("count kept", 5'h04, 16'h1234);
        for (int s = 0; s < 4; s++) begin
            wr(5'h04, 16'h0000);
            wr(5'h00, 16'h8000 | 16'(s << 4));
            repeat (2048) @(posedge clk_sys);
            wr(5'h00, 16'h0000);
            bus(1'b0, 5'h04, 16'h0000);
            check("prescale", near(rd, 16'(ps_exp[s])), 16'h0001);
        end
        wr(5'h00, 16'h8030);
        for (int i = 0; i < 4; i++) begin
            wr(5'h04, 16'h0000);
            repeat (600) @(posedge clk_sys);
        end
        wr(5'h00, 16'h0000);
        rc("prescaler clear", 5'h04, 16'h0000);
        $display("test registers and prescaler done");
        wr(5'h08, 16'h0005);
        wr(5'h00, 16'h8000);
        for (int i = 0; i < 20; i++) begin
            bus(1'b0, 5'h04, 16'h0000);
            check("wrap", {15'h0000, rd <= 16'h0005}, 16'h0001);
        end
        check("irq masked", {15'h0000, irq}, 16'h0000);
        rc("flag", 5'h0C, 16'h0001);
        wr(5'h10, 16'h0001);
        rc("mask", 5'h10, 16'h0001);
        repeat (30) @(posedge clk_sys);
        check("irq", {15'h0000, irq}, 16'h0001);
        wr(5'h00, 16'h0000);
        repeat (50) @(posedge clk_sys);
        rc("flag held", 5'h0C, 16'h0001);
        rc("flag cleared", 5'h0C, 16'h0000);
        check("irq off", {15'h0000, irq}, 16'h0000);
        wr(5'h08, 16'hFFFF);
        $display("test period match done");
        for (int i = 0; i < 2; i++) begin
            wr(5'h04, 16'h0000);
            cpu_idle <= 1'b1;
            wr(5'h00, i ? 16'h8000 : 16'hA000);
            repeat (400) @(posedge clk_sys);
            wr(5'h00, 16'h0000);
            cpu_idle <= 1'b0;
            bus(1'b0, 5'h04, 16'h0000);
            check("idle", i ? near(rd, 16'h0064) : rd, i ? 16'h0001 : 16'h0000);
        end
        wr(5'h04, 16'h0000);
        wr(5'h00, 16'h8040);
        repeat (200) @(posedge clk_sys);
        rc("gate low", 5'h04, 16'h0000);
        rc("no fall", 5'h0C, 16'h0000);
        gate_high <= 1'b1;
        repeat (400) @(posedge clk_sys);
        gate_high <= 1'b0;
        repeat (10) @(posedge clk_sys);
        wr(5'h00, 16'h0000);
        bus(1'b0, 5'h04, 16'h0000);
        check("gate high", near(rd, 16'h0064), 16'h0001);
        rc("fall flag", 5'h0C, 16'h0001);
        $display("test idle and gate done");
        wr(5'h04, 16'h0000);
        wr(5'h00, 16'h8002);
        pulses(8'h0A);
        rc("ext", 5'h04, 16'h000A);
        cpu_sleep <= 1'b1;
        pulses(8'h0A);
        rc("sleep async", 5'h04, 16'h0014);
        wr(5'h00, 16'h8006);
        pulses(8'h0A);
        rc("sleep sync", 5'h04, 16'h0014);
        cpu_sleep <= 1'b0;
        pulses(8'h0A);
        rc("sync", 5'h04, 16'h001E);
        $display("test external clock done");
        end_sim();
    end
endmodule : tb_sixteen_bit_gated_timer
